// file: mei_pkg.sv
package mei_pkg;
  // register bus geometry
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int ID_W   = 8;
  localparam int SRC_W  = 2;
  localparam int EVT_W  = 3;

  // byte addresses of the registers
  localparam logic [ADDR_W-1:0] OFS_MASKED_STATUS = 32'hC00A0014;
  localparam logic [ADDR_W-1:0] OFS_RAW_STATUS    = 32'hC00A0018;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SET    = 32'hC00A001C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK      = 32'hC00A0020;
  localparam logic [ADDR_W-1:0] OFS_SOURCE_CLEAR  = 32'hC00A0024;
  localparam logic [ADDR_W-1:0] OFS_REQUESTER_ID  = 32'hC00A0068;
  localparam logic [ADDR_W-1:0] OFS_ADDR_CAPTURE  = 32'hC00A006C;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS  = 32'hC00A0070;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK    = 32'hC00A0074;

  // source bit positions, shared by status, enable, mask and clear
  localparam int BIT_SEC = 0;
  localparam int BIT_GEN = 1;

  // event status bit positions
  localparam int EVT_SEC = 0;
  localparam int EVT_GEN = 1;
  localparam int EVT_CAP = 2;

  // capture control: re-arm command and captured flag
  localparam int BIT_CAP_CLEAR = 31;
  localparam int BIT_CAP_VALID = 0;

  // reset values
  localparam logic [SRC_W-1:0]  RST_SRC  = 2'h0;
  localparam logic [EVT_W-1:0]  RST_EVT  = 3'h0;
  localparam logic [ID_W-1:0]   RST_ID   = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO  = 32'h00000000;
endpackage

// file: mei_sticky.sv
`timescale 1ns/1ps
// bank of sticky flags; a set in the clear cycle wins
module mei_sticky #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] q_o
);
  // set dominates so no event is lost to a racing clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else begin
      q_o <= (q_o & ~clr_i) | set_i;
    end
  end
endmodule

// file: mei_id_capture.sv
`timescale 1ns/1ps
// holds the first offending id until re-armed
module mei_id_capture
  import mei_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         err_i,
  input  wire logic [W-1:0] id_i,
  input  wire logic         rearm_i,
  output logic      [W-1:0] id_o,
  output logic              valid_o,
  output logic              stored_o
);
  // a slot is free when empty or being re-armed this cycle
  logic free;
  assign free     = ~valid_o | rearm_i;
  assign stored_o = err_i & free;

  // id only loads into a free slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      id_o <= '0;
    end else if (stored_o) begin
      id_o <= id_i;
    end
  end

  // new capture beats a same-cycle re-arm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
    end else if (stored_o) begin
      valid_o <= 1'b1;
    end else if (rearm_i) begin
      valid_o <= 1'b0;
    end
  end
endmodule

// file: mei_irq_ctrl.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module mei_irq_ctrl
  import mei_pkg::*;
#(
  parameter int ID_BITS = ID_W
) (
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       RST_I,
  input  wire logic [mei_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [mei_pkg::DATA_W-1:0] WDATA_I,
  input  wire logic                       WR_I,
  input  wire logic                       RD_I,
  output logic      [mei_pkg::DATA_W-1:0] RDATA_O,
  input  wire logic                       GEN_ERR_I,
  input  wire logic                       SEC_ERR_I,
  input  wire logic [ID_BITS-1:0]         ERR_ID_I,
  output logic                            IRQ_O
);
  import mei_pkg::*;

  // address decode
  logic hit_masked;
  logic hit_raw;
  logic hit_enable;
  logic hit_mask;
  logic hit_clear;
  logic hit_id;
  logic hit_cap;
  logic hit_evt;
  logic hit_evt_mask;

  // write commands and the event read strobe
  logic wr_enable;
  logic wr_mask;
  logic wr_clear;
  logic wr_cap;
  logic wr_evt_mask;
  logic rd_evt;

  // source state
  logic [SRC_W-1:0] raw_q;
  logic [SRC_W-1:0] raw_set;
  logic [SRC_W-1:0] raw_clr;
  logic [SRC_W-1:0] en_q;
  logic [SRC_W-1:0] en_d;
  logic [SRC_W-1:0] masked;

  // capture state
  logic [ID_BITS-1:0] cap_id;
  logic               cap_valid;
  logic               cap_stored;
  logic               cap_rearm;
  logic               any_err;

  // event status for the system interrupt
  logic [EVT_W-1:0] evt_q;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic [EVT_W-1:0] evt_mask_q;
  logic             evt_pending;

  // read path
  logic [DATA_W-1:0] rd_d;
  logic [DATA_W-1:0] rdata_q;

  // full-width compare so aliases never answer
  assign hit_masked   = (ADDR_I == OFS_MASKED_STATUS);
  assign hit_raw      = (ADDR_I == OFS_RAW_STATUS);
  assign hit_enable   = (ADDR_I == OFS_ENABLE_SET);
  assign hit_mask     = (ADDR_I == OFS_IRQ_MASK);
  assign hit_clear    = (ADDR_I == OFS_SOURCE_CLEAR);
  assign hit_id       = (ADDR_I == OFS_REQUESTER_ID);
  assign hit_cap      = (ADDR_I == OFS_ADDR_CAPTURE);
  assign hit_evt      = (ADDR_I == OFS_EVENT_STATUS);
  assign hit_evt_mask = (ADDR_I == OFS_EVENT_MASK);

  // qualified strobes
  assign wr_enable   = WR_I & hit_enable;
  assign wr_mask     = WR_I & hit_mask;
  assign wr_clear    = WR_I & hit_clear;
  assign wr_cap      = WR_I & hit_cap;
  assign wr_evt_mask = WR_I & hit_evt_mask;
  assign rd_evt      = RD_I & hit_evt;

  // sources latch on every error, enables not consulted
  assign raw_set[BIT_GEN] = GEN_ERR_I;
  assign raw_set[BIT_SEC] = SEC_ERR_I;

  // write-one clear of latched sources, zeros ignored
  assign raw_clr[BIT_GEN] = wr_clear & WDATA_I[BIT_GEN];
  assign raw_clr[BIT_SEC] = wr_clear & WDATA_I[BIT_SEC];

  // raw latches: an error in the clear cycle stays pending
  mei_sticky #(
    .W (SRC_W)
  ) u_raw (
    .clk_i (CORE_CLK_I),
    .rst_i (RST_I),
    .set_i (raw_set),
    .clr_i (raw_clr),
    .q_o   (raw_q)
  );

  // enable next value: set register adds, mask register removes
  always_comb begin
    en_d = en_q;
    if (wr_enable) begin
      en_d = en_q | WDATA_I[SRC_W-1:0];
    end
    if (wr_mask) begin
      en_d[BIT_GEN] = en_q[BIT_GEN] & ~WDATA_I[BIT_GEN];
      en_d[BIT_SEC] = en_q[BIT_SEC] & ~WDATA_I[BIT_SEC];
    end
  end

  // enables come up masked
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      en_q <= RST_SRC;
    end else begin
      en_q <= en_d;
    end
  end

  // per-source masked status
  assign masked = raw_q & en_q;

  // re-arm command for the id capture
  assign cap_rearm = wr_cap & WDATA_I[BIT_CAP_CLEAR];

  // either source counts as an error for capture
  assign any_err = GEN_ERR_I | SEC_ERR_I;

  // first error id held until re-armed
  mei_id_capture #(
    .W (ID_BITS)
  ) u_cap (
    .clk_i    (CORE_CLK_I),
    .rst_i    (RST_I),
    .err_i    (any_err),
    .id_i     (ERR_ID_I),
    .rearm_i  (cap_rearm),
    .id_o     (cap_id),
    .valid_o  (cap_valid),
    .stored_o (cap_stored)
  );

  // events feeding the system interrupt status
  assign evt_set[EVT_SEC] = SEC_ERR_I;
  assign evt_set[EVT_GEN] = GEN_ERR_I;
  assign evt_set[EVT_CAP] = cap_stored;

  // read of the event register clears all its bits
  assign evt_clr = {EVT_W{rd_evt}};

  // sticky events, set beats read-clear
  mei_sticky #(
    .W (EVT_W)
  ) u_evt (
    .clk_i (CORE_CLK_I),
    .rst_i (RST_I),
    .set_i (evt_set),
    .clr_i (evt_clr),
    .q_o   (evt_q)
  );

  // event mask, plain read/write
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      evt_mask_q <= RST_EVT;
    end else if (wr_evt_mask) begin
      evt_mask_q <= WDATA_I[EVT_W-1:0];
    end
  end

  // any unmasked event pending
  assign evt_pending = |(evt_q & evt_mask_q);

  // level interrupt; combinational so it tracks the flops directly
  assign IRQ_O = (|masked) | evt_pending;

  // read mux; unmapped and write-only addresses give zero
  always_comb begin
    rd_d = RD_ZERO;
    if (hit_masked) begin
      rd_d[SRC_W-1:0] = masked;
    end else if (hit_raw) begin
      rd_d[SRC_W-1:0] = raw_q;
    end else if (hit_enable) begin
      rd_d[SRC_W-1:0] = en_q;
    end else if (hit_mask) begin
      rd_d = RD_ZERO;
    end else if (hit_clear) begin
      rd_d = RD_ZERO;
    end else if (hit_id) begin
      rd_d[ID_BITS-1:0] = cap_id;
    end else if (hit_cap) begin
      rd_d[BIT_CAP_VALID] = cap_valid;
    end else if (hit_evt) begin
      rd_d[EVT_W-1:0] = evt_q;
    end else if (hit_evt_mask) begin
      rd_d[EVT_W-1:0] = evt_mask_q;
    end
  end

  // read data valid only the cycle after the strobe
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      rdata_q <= RD_ZERO;
    end else if (RD_I) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= RD_ZERO;
    end
  end

  assign RDATA_O = rdata_q;
endmodule

// file: mei_irq_ctrl_properties.sv
`timescale 1ns/1ps
// port-level checks of the error interrupt control block
module mei_props
  import mei_pkg::*;
#(
  parameter int ID_BITS = 8
) (
  input wire logic                       CORE_CLK_I,
  input wire logic                       RST_I,
  input wire logic [mei_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [mei_pkg::DATA_W-1:0] WDATA_I,
  input wire logic                       WR_I,
  input wire logic                       RD_I,
  input wire logic [mei_pkg::DATA_W-1:0] RDATA_O,
  input wire logic                       GEN_ERR_I,
  input wire logic                       SEC_ERR_I,
  input wire logic                       IRQ_O
);
  // decoded strobes, full address compare only
  wire rd_en  = RD_I && (ADDR_I == OFS_ENABLE_SET);
  wire rd_msk = RD_I && (ADDR_I == OFS_IRQ_MASK);
  wire rd_clr = RD_I && (ADDR_I == OFS_SOURCE_CLEAR);
  wire rd_id  = RD_I && (ADDR_I == OFS_REQUESTER_ID);
  wire rd_raw = RD_I && (ADDR_I == OFS_RAW_STATUS);
  wire wr_en  = WR_I && (ADDR_I == OFS_ENABLE_SET);
  wire wr_msk = WR_I && (ADDR_I == OFS_IRQ_MASK);
  wire wr_clr = WR_I && (ADDR_I == OFS_SOURCE_CLEAR);
  // clear writes with no racing error, so the clear must be seen
  wire clr_gen = wr_clr && WDATA_I[1] && !GEN_ERR_I;
  wire clr_sec = wr_clr && WDATA_I[0] && !SEC_ERR_I;

  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  a_mask_reads_zero: assert property (rd_msk |=> RDATA_O == RD_ZERO)
    else $error("mask register read back nonzero");
  a_clear_reads_zero: assert property (rd_clr |=> RDATA_O == RD_ZERO)
    else $error("source clear register read back nonzero");
  a_id_upper_zero: assert property (rd_id |=> RDATA_O[31:8] == 24'h000000)
    else $error("requester id upper bits nonzero");
  a_enable_set_sticks: assert property (wr_en && WDATA_I[1] ##1 rd_en |=> RDATA_O[1])
    else $error("general enable not set by write");
  a_gen_mask_disables: assert property (wr_msk && WDATA_I[1] ##1 rd_en |=> !RDATA_O[1])
    else $error("general enable survived mask write");
  a_sec_mask_disables: assert property (wr_msk && WDATA_I[0] ##1 rd_en |=> !RDATA_O[0])
    else $error("security enable survived mask write");
  a_raw_sets_always: assert property (GEN_ERR_I ##1 rd_raw |=> RDATA_O[1])
    else $error("general raw status not set by error");
  a_gen_clear_works: assert property (clr_gen ##1 rd_raw |=> !RDATA_O[1])
    else $error("general raw status not cleared");
  a_sec_clear_works: assert property (clr_sec ##1 rd_raw |=> !RDATA_O[0])
    else $error("security raw status not cleared");

  // main scenarios reached
  c_irq_raised: cover property ($rose(IRQ_O));
  c_id_read: cover property (rd_id);
  c_sec_clear: cover property (wr_clr && WDATA_I[0]);
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end
module tb_top;
  import mei_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              gen = 1'b0;
  logic              sec = 1'b0;
  logic [ID_W-1:0]   id = '0;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  int                err_count = 0;
  int                samples_checked = 0;
  int                cycles = 0;

  mei_irq_ctrl #(.ID_BITS(ID_W)) mei_irq_ctrl_i (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .GEN_ERR_I(gen),
    .SEC_ERR_I(sec), .ERR_ID_I(id), .IRQ_O(irq));

  // 25 MHz core clock
  always #20 clk = ~clk;

  // one cycle of every input, so back-to-back accesses never leave a gap
  task automatic drive(input logic w, r, g, s, input logic [31:0] a, d, input logic [7:0] i);
    @(posedge clk);
    wr <= w;
    rd <= r;
    gen <= g;
    sec <= s;
    addr <= a;
    wdata <= d;
    id <= i;
  endtask

  task automatic wr_reg(input logic [31:0] a, d);
    drive(1'b1, 1'b0, 1'b0, 1'b0, a, d, 8'h00);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [31:0] a, exp);
    drive(1'b0, 1'b1, 1'b0, 1'b0, a, 32'h0, 8'h00);
    drive(1'b0, 1'b0, 1'b0, 1'b0, a, 32'h0, 8'h00);
    #1;
    `CHK(rdata, exp)
  endtask

  task automatic err(input logic g, s, input logic [7:0] i);
    drive(1'b0, 1'b0, g, s, 32'h0, 32'h0, i);
  endtask

  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 72 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_ENABLE_SET, 32'h0);
    rd_reg(OFS_REQUESTER_ID, 32'h0);
    wr_reg(OFS_ENABLE_SET, 32'h3);
    wr_reg(OFS_ENABLE_SET, 32'h0);
    rd_reg(OFS_ENABLE_SET, 32'h3);
    wr_reg(OFS_IRQ_MASK, 32'h2);
    rd_reg(OFS_ENABLE_SET, 32'h1);
    rd_reg(OFS_IRQ_MASK, 32'h0);
    wr_reg(OFS_IRQ_MASK, 32'h0);
    rd_reg(OFS_ENABLE_SET, 32'h1);
    wr_reg(OFS_IRQ_MASK, 32'h1);
    rd_reg(OFS_ENABLE_SET, 32'h0);
    err(1'b1, 1'b0, 8'h5A);
    rd_reg(OFS_RAW_STATUS, 32'h2);
    `CHK(irq, 1'b0)
    rd_reg(OFS_EVENT_STATUS, 32'h6);
    rd_reg(OFS_EVENT_STATUS, 32'h0);
    rd_reg(OFS_MASKED_STATUS, 32'h0);
    rd_reg(OFS_REQUESTER_ID, 32'h5A);
    wr_reg(OFS_ENABLE_SET, 32'h2);
    rd_reg(OFS_ENABLE_SET, 32'h2);
    rd_reg(OFS_MASKED_STATUS, 32'h2);
    `CHK(irq, 1'b1)
    err(1'b0, 1'b1, 8'hC3);
    rd_reg(OFS_REQUESTER_ID, 32'h5A);
    wr_reg(OFS_ADDR_CAPTURE, 32'h80000000);
    err(1'b1, 1'b0, 8'h3C);
    rd_reg(OFS_REQUESTER_ID, 32'h3C);
    wr_reg(OFS_SOURCE_CLEAR, 32'h0);
    rd_reg(OFS_RAW_STATUS, 32'h3);
    wr_reg(OFS_SOURCE_CLEAR, 32'h2);
    rd_reg(OFS_RAW_STATUS, 32'h1);
    `CHK(irq, 1'b0)
    wr_reg(OFS_SOURCE_CLEAR, 32'hFFFFFFFF);
    rd_reg(OFS_RAW_STATUS, 32'h0);
    rd_reg(OFS_SOURCE_CLEAR, 32'h0);
    // unmapped place: write lost, read empty
    wr_reg(32'hC00A0030, 32'hFFFFFFFF);
    rd_reg(32'hC00A0030, 32'h0);
    // id still held from the last error, event path drives the line
    rd_reg(OFS_ADDR_CAPTURE, 32'h1);
    wr_reg(OFS_EVENT_MASK, 32'h4);
    rd_reg(OFS_EVENT_MASK, 32'h4);
    `CHK(irq, 1'b1)
    rd_reg(OFS_EVENT_STATUS, 32'h7);
    `CHK(irq, 1'b0)
    // second reset in mid-run drops the enables
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_ENABLE_SET, 32'h0);
    `CHK(irq, 1'b0)
    conclude();
  end
endmodule

bind mei_irq_ctrl mei_props #(.ID_BITS(ID_BITS)) mei_props_i (.CORE_CLK_I(CORE_CLK_I),
  .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .GEN_ERR_I(GEN_ERR_I), .SEC_ERR_I(SEC_ERR_I), .IRQ_O(IRQ_O));
